// >>> dac_if_pkg.sv
// constants, field layout and carrier types of the dac serial host interface
// assumes a 24-bit framed serial link and a write-only two-wire slave
package dac_if_pkg;

	// ==========================================================================
	// frame layout
	localparam int           FRAME_BITS  = 24;
	localparam logic [4:0]   FRAME_CNT   = 5'h18;
	localparam logic [4:0]   CNT_FIRST   = 5'h01;
	localparam int           AB_BIT      = 23;
	localparam int           RW_BIT      = 22;
	localparam int           CH_LSB      = 16;
	localparam int           CH_W        = 4;
	localparam int           SEL_LSB     = 14;
	localparam int           DATA_W      = 14;
	localparam int           NUM_CH      = 16;
	localparam int           ADDR_INFO_W = 10;

	// ==========================================================================
	// reset values of the channel registers and the readback word
	localparam logic [13:0]  DATA_RST    = 14'h0000;
	localparam logic [13:0]  OFFS_RST    = 14'h2000;
	localparam logic [13:0]  GAIN_RST    = 14'h3ffe;
	localparam logic [23:0]  RB_RST      = 24'h00_0000;

	// ==========================================================================
	// two-wire slave
	localparam logic [4:0]   SLAVE_ADDR_HI = 5'h15;
	localparam logic [3:0]   BYTE_BITS     = 4'h8;
	localparam logic [3:0]   BITCNT_RST    = 4'h0;
	localparam logic [7:0]   BYTE_RST      = 8'h00;

	typedef enum logic [1:0] {
		SEL_SFR  = 2'h0,
		SEL_GAIN = 2'h1,
		SEL_OFFS = 2'h2,
		SEL_DATA = 2'h3
	} reg_sel_e;

	typedef enum logic [5:0] {
		TW_IDLE     = 6'h01,
		TW_ADDR     = 6'h02,
		TW_ADDR_ACK = 6'h04,
		TW_DATA     = 6'h08,
		TW_DATA_ACK = 6'h10,
		TW_IGNORE   = 6'h20
	} tw_state_e;

	// ==========================================================================
	// carriers
	typedef struct packed {
		logic              ab;
		logic [CH_W-1:0]   channel_address;
		reg_sel_e          sel;
		logic [DATA_W-1:0] payload_word;
	} wr_cmd_s;

	localparam wr_cmd_s WR_RST = '{ab: 1'b0, channel_address: 4'h0, sel: SEL_SFR, payload_word: 14'h0000};

	typedef struct packed {
		logic              valid;
		logic [7:0]        data;
	} tw_byte_s;

endpackage

// >>> dac_serial_host_interface.sv
// serial host interface: 24-bit framed link plus write-only two-wire slave
// assumes the host owns sclk/sync/din and the bus pull-ups sit outside
`timescale 1ns/1ns
`default_nettype none

module dac_serial_host_interface (
	// system
	input  wire logic                    i_ref_clk,
	input  wire logic                    i_rst,
	// configuration pins and bits
	input  wire logic                    i_spi_mode,
	input  wire logic                    i_chain_enable_pin,
	input  wire logic                    i_toggle_enable,
	input  wire logic                    i_addr_strap_hi,
	input  wire logic                    i_addr_strap_lo,
	// framed serial link
	input  wire logic                    i_sclk,
	input  wire logic                    i_sync_n,
	input  wire logic                    i_din,
	output logic                         o_sdo,
	// two-wire bus (clock is only ever read)
	input  wire logic                    i_scl,
	input  wire logic                    i_sda,
	output logic                         o_sda_o,
	output logic                         o_sda_oe,
	// received commands
	output logic                         o_wr_valid,
	output dac_if_pkg::wr_cmd_s          o_wr,
	output logic                         o_bad_frame,
	output logic                         o_rb_pending,
	output dac_if_pkg::tw_byte_s         o_tw_byte
);

	// ==========================================================================
	// state types
	typedef struct packed {
		logic                                                           chain_m;
		logic                                                           chain_s;
		logic [dac_if_pkg::FRAME_BITS-1:0]                              shift;
		logic [4:0]                                                     cnt;
	} link_s;

	typedef struct packed {
		logic                                                           sync_m;
		logic                                                           sync_s;
		logic                                                           sync_p;
		logic                                                           scl_m;
		logic                                                           scl_s;
		logic                                                           scl_p;
		logic                                                           sda_m;
		logic                                                           sda_s;
		logic                                                           sda_p;
		logic                                                           mode_m;
		logic                                                           mode_s;
		logic [1:0]                                                     strap_m;
		logic [1:0]                                                     strap_s;
		logic [dac_if_pkg::NUM_CH-1:0][dac_if_pkg::DATA_W-1:0]          data_a;
		logic [dac_if_pkg::NUM_CH-1:0][dac_if_pkg::DATA_W-1:0]          data_b;
		logic [dac_if_pkg::NUM_CH-1:0][dac_if_pkg::DATA_W-1:0]          offs;
		logic [dac_if_pkg::NUM_CH-1:0][dac_if_pkg::DATA_W-1:0]          gain;
		logic [dac_if_pkg::FRAME_BITS-1:0]                              rb_word;
		logic                                                           rb_pending;
		logic                                                           wr_valid;
		dac_if_pkg::wr_cmd_s                                            wr;
		logic                                                           bad_frame;
		dac_if_pkg::tw_state_e                                          tw_st;
		logic [3:0]                                                     bitcnt;
		logic [7:0]                                                     sh;
		logic                                                           sda_oe;
		dac_if_pkg::tw_byte_s                                           tw_byte;
	} ref_s;

	link_s lk_r;
	link_s lk_nxt;
	ref_s  r_r;
	ref_s  r_nxt;
	logic  started_r;
	logic  sdo_r;

	// ==========================================================================
	// link domain: shifting on the falling sclk edge
	// the frame start flag is cleared by sync itself, since sclk may stand still
	// between frames and no clock edge is guaranteed there
	always_ff @(negedge i_sclk or posedge i_sync_n) begin
		if (i_sync_n) begin
			started_r <= 1'b0;
		end else begin
			started_r <= 1'b1;
		end
	end

	always_comb begin
		lk_nxt         = lk_r;
		lk_nxt.chain_m = i_chain_enable_pin;
		lk_nxt.chain_s = lk_r.chain_m;
		if (!i_sync_n) begin
			if (!started_r) begin
				// first bit: counter restarts, readback word preloaded behind it
				lk_nxt.shift = {r_r.rb_word[dac_if_pkg::FRAME_BITS-2:0], i_din};
				lk_nxt.cnt   = dac_if_pkg::CNT_FIRST;
			end else if (lk_r.chain_s || (lk_r.cnt < dac_if_pkg::FRAME_CNT)) begin
				lk_nxt.shift = {lk_r.shift[dac_if_pkg::FRAME_BITS-2:0], i_din};
				if (lk_r.cnt < dac_if_pkg::FRAME_CNT) begin
					lk_nxt.cnt = 5'(lk_r.cnt + 5'h01);
				end
			end
		end
	end

	// no reset here: the link clock is not running at reset, and every frame
	// reloads the shift register and counter at its first bit
	always_ff @(negedge i_sclk) begin
		lk_r <= lk_nxt;
	end

	// output moves on the rising edge so it is settled at the next falling one
	always_ff @(posedge i_sclk) begin
		sdo_r <= started_r ? lk_r.shift[dac_if_pkg::FRAME_BITS-1]
		                   : r_r.rb_word[dac_if_pkg::FRAME_BITS-1];
	end

	// before the first bit the readback msb stands from the sync fall
	assign o_sdo = started_r ? sdo_r : r_r.rb_word[dac_if_pkg::FRAME_BITS-1];

	// ==========================================================================
	// reference domain: frame latch, channel registers, two-wire slave
	always_comb begin
		logic                                  sync_rise;
		logic [dac_if_pkg::FRAME_BITS-1:0]     frame;
		logic [dac_if_pkg::CH_W-1:0]           ch;
		dac_if_pkg::reg_sel_e                  sel;
		logic                                  use_b;
		logic [dac_if_pkg::DATA_W-1:0]         rd_val;
		logic                                  scl_rise;
		logic                                  scl_fall;
		logic                                  tw_start;
		logic                                  tw_stop;
		logic [6:0]                            own_addr;

		rd_val         = dac_if_pkg::DATA_RST;
		r_nxt          = r_r;
		r_nxt.sync_m   = i_sync_n;
		r_nxt.sync_s   = r_r.sync_m;
		r_nxt.sync_p   = r_r.sync_s;
		r_nxt.scl_m    = i_scl;
		r_nxt.scl_s    = r_r.scl_m;
		r_nxt.scl_p    = r_r.scl_s;
		r_nxt.sda_m    = i_sda;
		r_nxt.sda_s    = r_r.sda_m;
		r_nxt.sda_p    = r_r.sda_s;
		r_nxt.mode_m   = i_spi_mode;
		r_nxt.mode_s   = r_r.mode_m;
		r_nxt.strap_m  = {i_addr_strap_hi, i_addr_strap_lo};
		r_nxt.strap_s  = r_r.strap_m;
		r_nxt.wr_valid = 1'b0;
		r_nxt.bad_frame     = 1'b0;
		r_nxt.tw_byte.valid = 1'b0;

		// --- framed link ---
		// link words are read a few cycles after sync rises; they stay still
		// until the next sync fall, which is the crossing's handshake
		sync_rise = r_r.sync_s & ~r_r.sync_p & r_r.mode_s;
		frame     = lk_r.shift;
		ch        = frame[dac_if_pkg::CH_LSB +: dac_if_pkg::CH_W];
		sel       = dac_if_pkg::reg_sel_e'(frame[dac_if_pkg::SEL_LSB +: 2]);
		use_b     = frame[dac_if_pkg::AB_BIT] & i_toggle_enable;
		case (sel)
			dac_if_pkg::SEL_DATA: begin
				rd_val = use_b ? r_r.data_b[ch] : r_r.data_a[ch];
			end
			dac_if_pkg::SEL_OFFS: begin
				rd_val = r_r.offs[ch];
			end
			dac_if_pkg::SEL_GAIN: begin
				rd_val = r_r.gain[ch];
			end
			default: begin
				rd_val = dac_if_pkg::DATA_RST;
			end
		endcase

		if (sync_rise) begin
			if (lk_r.cnt != dac_if_pkg::FRAME_CNT) begin
				r_nxt.bad_frame = 1'b1;
			end else if (frame[dac_if_pkg::RW_BIT]) begin
				// readback request: nothing is written
				r_nxt.rb_word    = {frame[dac_if_pkg::FRAME_BITS-1 -: dac_if_pkg::ADDR_INFO_W], rd_val};
				r_nxt.rb_pending = 1'b1;
			end else begin
				r_nxt.rb_word    = dac_if_pkg::RB_RST;
				r_nxt.rb_pending = 1'b0;
				r_nxt.wr_valid   = 1'b1;
				r_nxt.wr.ab      = use_b;
				r_nxt.wr.channel_address = ch;
				r_nxt.wr.sel     = sel;
				r_nxt.wr.payload_word = frame[dac_if_pkg::DATA_W-1:0];
				case (sel)
					dac_if_pkg::SEL_DATA: begin
						if (use_b) begin
							r_nxt.data_b[ch] = frame[dac_if_pkg::DATA_W-1:0];
						end else begin
							r_nxt.data_a[ch] = frame[dac_if_pkg::DATA_W-1:0];
						end
					end
					dac_if_pkg::SEL_OFFS: begin
						r_nxt.offs[ch] = frame[dac_if_pkg::DATA_W-1:0];
					end
					dac_if_pkg::SEL_GAIN: begin
						r_nxt.gain[ch] = frame[dac_if_pkg::DATA_W-1:0];
					end
					default: begin
						// special functions are decoded downstream from o_wr
					end
				endcase
			end
		end

		// --- two-wire slave, oversampled; 400 khz leaves >60 samples per phase ---
		scl_rise = r_r.scl_s & ~r_r.scl_p;
		scl_fall = ~r_r.scl_s & r_r.scl_p;
		tw_start = r_r.scl_s & r_r.scl_p & r_r.sda_p & ~r_r.sda_s;
		tw_stop  = r_r.scl_s & r_r.scl_p & ~r_r.sda_p & r_r.sda_s;
		own_addr = {dac_if_pkg::SLAVE_ADDR_HI, r_r.strap_s};

		if (r_r.mode_s) begin
			r_nxt.tw_st  = dac_if_pkg::TW_IDLE;
			r_nxt.sda_oe = 1'b0;
		end else if (tw_start) begin
			// repeated start lands here too and keeps the slave listening
			r_nxt.tw_st  = dac_if_pkg::TW_ADDR;
			r_nxt.bitcnt = dac_if_pkg::BITCNT_RST;
			r_nxt.sda_oe = 1'b0;
		end else if (tw_stop) begin
			r_nxt.tw_st  = dac_if_pkg::TW_IDLE;
			r_nxt.sda_oe = 1'b0;
		end else begin
			case (r_r.tw_st)
				dac_if_pkg::TW_IDLE: begin
					r_nxt.sda_oe = 1'b0;
				end
				dac_if_pkg::TW_ADDR: begin
					if (scl_rise) begin
						r_nxt.sh     = {r_r.sh[6:0], r_r.sda_s};
						r_nxt.bitcnt = 4'(r_r.bitcnt + 4'h1);
					end else if (scl_fall && (r_r.bitcnt == dac_if_pkg::BYTE_BITS)) begin
						if ((r_r.sh[7:1] == own_addr) && !r_r.sh[0]) begin
							r_nxt.tw_st  = dac_if_pkg::TW_ADDR_ACK;
							r_nxt.sda_oe = 1'b1;
						end else begin
							r_nxt.tw_st  = dac_if_pkg::TW_IGNORE;
						end
					end
				end
				dac_if_pkg::TW_DATA: begin
					if (scl_rise) begin
						r_nxt.sh     = {r_r.sh[6:0], r_r.sda_s};
						r_nxt.bitcnt = 4'(r_r.bitcnt + 4'h1);
					end else if (scl_fall && (r_r.bitcnt == dac_if_pkg::BYTE_BITS)) begin
						r_nxt.tw_st        = dac_if_pkg::TW_DATA_ACK;
						r_nxt.sda_oe       = 1'b1;
						r_nxt.tw_byte.valid = 1'b1;
						r_nxt.tw_byte.data  = r_r.sh;
					end
				end
				dac_if_pkg::TW_ADDR_ACK, dac_if_pkg::TW_DATA_ACK: begin
					// ack held through the ninth clock, released at its fall
					if (scl_fall) begin
						r_nxt.sda_oe = 1'b0;
						r_nxt.tw_st  = dac_if_pkg::TW_DATA;
						r_nxt.bitcnt = dac_if_pkg::BITCNT_RST;
					end
				end
				dac_if_pkg::TW_IGNORE: begin
					r_nxt.sda_oe = 1'b0;
				end
				default: begin
					r_nxt.tw_st  = dac_if_pkg::TW_IDLE;
					r_nxt.sda_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			r_r.sync_m     <= 1'b1;
			r_r.sync_s     <= 1'b1;
			r_r.sync_p     <= 1'b1;
			r_r.scl_m      <= 1'b1;
			r_r.scl_s      <= 1'b1;
			r_r.scl_p      <= 1'b1;
			r_r.sda_m      <= 1'b1;
			r_r.sda_s      <= 1'b1;
			r_r.sda_p      <= 1'b1;
			r_r.mode_m     <= 1'b1;
			r_r.mode_s     <= 1'b1;
			r_r.strap_m    <= 2'h0;
			r_r.strap_s    <= 2'h0;
			r_r.data_a     <= {dac_if_pkg::NUM_CH{dac_if_pkg::DATA_RST}};
			r_r.data_b     <= {dac_if_pkg::NUM_CH{dac_if_pkg::DATA_RST}};
			r_r.offs       <= {dac_if_pkg::NUM_CH{dac_if_pkg::OFFS_RST}};
			r_r.gain       <= {dac_if_pkg::NUM_CH{dac_if_pkg::GAIN_RST}};
			r_r.rb_word    <= dac_if_pkg::RB_RST;
			r_r.rb_pending <= 1'b0;
			r_r.wr_valid   <= 1'b0;
			r_r.wr         <= dac_if_pkg::WR_RST;
			r_r.bad_frame  <= 1'b0;
			r_r.tw_st      <= dac_if_pkg::TW_IDLE;
			r_r.bitcnt     <= dac_if_pkg::BITCNT_RST;
			r_r.sh         <= dac_if_pkg::BYTE_RST;
			r_r.sda_oe     <= 1'b0;
			r_r.tw_byte    <= '{valid: 1'b0, data: dac_if_pkg::BYTE_RST};
		end else begin
			r_r <= r_nxt;
		end
	end

	// ==========================================================================
	// outputs
	assign o_sda_o      = 1'b0; // open drain: only ever pulls low
	assign o_sda_oe     = r_r.sda_oe;
	assign o_wr_valid   = r_r.wr_valid;
	assign o_wr         = r_r.wr;
	assign o_bad_frame  = r_r.bad_frame;
	assign o_rb_pending = r_r.rb_pending;
	assign o_tw_byte    = r_r.tw_byte;

endmodule // dac_serial_host_interface

`default_nettype wire

// >>> dac_shi_chk.sv
// checker: port assertions of the serial host interface
// assumes it is bound onto dac_serial_host_interface
`timescale 1ns/1ns
`default_nettype none
module dac_shi_chk (
	// system
	input wire logic                 i_ref_clk,
	input wire logic                 i_rst,
	// watched pins
	input wire logic                 i_sync_n,
	input wire logic                 i_scl,
	input wire logic                 o_sda_o,
	input wire logic                 o_sda_oe,
	input wire logic                 o_wr_valid,
	input wire dac_if_pkg::wr_cmd_s  o_wr,
	input wire logic                 o_bad_frame,
	input wire logic                 o_rb_pending,
	input wire dac_if_pkg::tw_byte_s o_tw_byte
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);
	// ==========================================================================
	// framed link
	// results only once sync has been high long enough to cross over
	sequence sync_held_s;
		i_sync_n && $past(i_sync_n) && $past(i_sync_n, 2);
	endsequence
	wr_latch_a: assert property (o_wr_valid |-> sync_held_s) else $error("write outside sync high");
	bad_latch_a: assert property (o_bad_frame |-> sync_held_s) else $error("bad frame outside sync high");
	wr_pulse_a: assert property (o_wr_valid |=> !o_wr_valid) else $error("write pulse too long");
	bad_quiet_a: assert property (o_bad_frame |-> !o_wr_valid && $stable(o_wr) && $stable(o_rb_pending))
		else $error("bad frame changed state");
	wr_hold_a: assert property (!o_wr_valid |-> $stable(o_wr)) else $error("command changed without write");
	rb_latch_a: assert property ($changed(o_rb_pending) |-> sync_held_s) else $error("readback flag moved early");
	read_nowr_a: assert property ($rose(o_rb_pending) |-> !o_wr_valid) else $error("read frame wrote");
	// ==========================================================================
	// two-wire slave
	sequence ack_on_s;
		$rose(o_sda_oe) ##0 !i_scl;
	endsequence
	ack_low_a: assert property (o_sda_oe |-> !o_sda_o) else $error("ack not pulling low");
	ack_rise_a: assert property ($rose(o_sda_oe) |-> ack_on_s) else $error("ack rose with scl high");
	ack_stand_a: assert property ($rose(o_sda_oe) |-> o_sda_oe [*8]) else $error("ack too short");
	ack_fall_a: assert property ($fell(o_sda_oe) |-> !i_scl) else $error("ack dropped with scl high");
	byte_ack_a: assert property (o_tw_byte.valid |-> ack_on_s ##1 !o_tw_byte.valid)
		else $error("byte valid without ack");
endmodule // dac_shi_chk
bind dac_serial_host_interface dac_shi_chk dac_shi_chk_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
	.i_sync_n(i_sync_n), .i_scl(i_scl), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .o_wr_valid(o_wr_valid),
	.o_wr(o_wr), .o_bad_frame(o_bad_frame), .o_rb_pending(o_rb_pending), .o_tw_byte(o_tw_byte));
`default_nettype wire

// >>> dac_host_model.sv
// host model: framed-link master and two-wire bus master
// assumes the bench resolves sda and feeds it back
`timescale 1ns/1ns
`default_nettype none
module dac_host_model (
	// framed link
	output logic      o_sclk,
	output logic      o_sync_n,
	output logic      o_din,
	input  wire logic i_sdo,
	// two-wire bus
	output logic      o_scl,
	output logic      o_sda_m,
	input  wire logic i_sda
);
	localparam int Q = 625;
	initial begin
		o_sclk = 1'b1;
		o_sync_n = 1'b1;
		o_din = 1'b0;
		o_scl = 1'b1;
		o_sda_m = 1'b1;
	end
	// ==========================================================================
	// framed link, sclk idles high and stands still outside frames
	task automatic frame(input logic [47:0] w, input int n, output logic [47:0] rx);
		rx = '0;
		o_sync_n = 1'b0;
		#63;
		for (int i = n - 1; i >= 0; i--) begin
			o_din = w[i];
			#31;
			rx[i] = i_sdo;
			o_sclk = 1'b0;
			#62;
			o_sclk = 1'b1;
			#32;
		end
		o_sync_n = 1'b1;
		o_din = ~o_din;
		#400;
	endtask
	// ==========================================================================
	// two-wire bus at 400 khz
	task automatic tw_start();
		o_sda_m = 1'b1;
		#Q o_scl = 1'b1;
		#Q o_sda_m = 1'b0;
		#Q o_scl = 1'b0;
		#Q;
	endtask
	task automatic tw_stop();
		o_sda_m = 1'b0;
		#Q o_scl = 1'b1;
		#Q o_sda_m = 1'b1;
		#Q;
	endtask
	task automatic tw_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			o_sda_m = b[i];
			#Q o_scl = 1'b1;
			#(2 * Q) o_scl = 1'b0;
			#Q;
		end
		o_sda_m = 1'b1;
		#Q o_scl = 1'b1;
		#Q ack = !i_sda;
		#Q o_scl = 1'b0;
		#Q;
	endtask
endmodule // dac_host_model
`default_nettype wire

// >>> dac_serial_host_interface_test.sv
// testbench of the serial host interface
// assumes the host model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module dac_serial_host_interface_test;
	logic                 clk = 1'b0;
	logic                 rst = 1'b1;
	logic                 mode = 1'b1;
	logic                 chain = 1'b0;
	logic                 tog = 1'b0;
	logic                 st_hi = 1'b0;
	logic                 st_lo = 1'b0;
	logic                 sclk, sync_n, din, sdo, scl, sda_m, sda, sda_o, sda_oe, wr_valid, bad, rb, ack;
	dac_if_pkg::wr_cmd_s  wr;
	dac_if_pkg::tw_byte_s twb;
	logic [47:0]          rx;
	int                   err_count = 0;
	int                   samples_checked = 0;
	int                   wr_cnt = 0;
	int                   bad_cnt = 0;
	int                   tw_cnt = 0;
	always #10 clk = ~clk;
	// wired-and bus, the slave only ever pulls low
	assign sda = o_pull(sda_oe, sda_o, sda_m);
	function automatic logic o_pull(input logic oe, input logic o, input logic m);
		return oe ? (o & m) : m;
	endfunction
	always @(posedge clk) begin
		wr_cnt <= wr_cnt + int'(wr_valid === 1'b1);
		bad_cnt <= bad_cnt + int'(bad === 1'b1);
		tw_cnt <= tw_cnt + int'(twb.valid === 1'b1);
	end
	dac_serial_host_interface dac_serial_host_interface_inst (.i_ref_clk(clk), .i_rst(rst), .i_spi_mode(mode),
		.i_chain_enable_pin(chain), .i_toggle_enable(tog), .i_addr_strap_hi(st_hi), .i_addr_strap_lo(st_lo),
		.i_sclk(sclk), .i_sync_n(sync_n), .i_din(din), .o_sdo(sdo), .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o),
		.o_sda_oe(sda_oe), .o_wr_valid(wr_valid), .o_wr(wr), .o_bad_frame(bad), .o_rb_pending(rb), .o_tw_byte(twb));
	dac_host_model dac_host_model_inst (.o_sclk(sclk), .o_sync_n(sync_n), .o_din(din), .i_sdo(sdo),
		.o_scl(scl), .o_sda_m(sda_m), .i_sda(sda));
	// ==========================================================================
	// helpers
	function automatic logic [23:0] fld(input logic [23:0] f);
		return {3'h0, f[23], f[19:16], f[15:14], f[13:0]};
	endfunction
	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic send(input logic [47:0] w, input int n);
		dac_host_model_inst.frame(w, n, rx);
	endtask
	task automatic rb_one(input logic [23:0] req, input logic [13:0] val);
		int w0;
		w0 = wr_cnt;
		send({24'h0, req}, 24);
		chk(24'(rb), 24'h1);
		chk(24'(wr_cnt), 24'(w0));
		send(48'h0, 24);
		chk(rx[23:0], {req[23:14], val});
		chk(24'(rb), 24'h0);
	endtask
	// ==========================================================================
	// scenarios
	task automatic t_readback();
		chk(24'(wr), 24'h0);
		rb_one(24'h40_4000, 14'h3ffe);
		rb_one(24'h40_8000, 14'h2000);
		$display("test readback done");
	endtask
	task automatic t_writes();
		logic [23:0] f;
		@(posedge clk) tog <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			f = 24'h80_0000 | 24'((s * 5) << 16) | 24'(s << 14) | 24'(14'h1234 + s);
			send({24'h0, f}, 24);
			chk(24'(wr), fld(f));
		end
		rb_one(24'hcf_c000, 14'h1237);
		@(posedge clk) tog <= 1'b0;
		// toggle off: the host keeps the a/b bit at zero
		send(48'h0f_c555, 24);
		chk(24'(wr), fld(24'h0f_c555));
		rb_one(24'h4f_c000, 14'h0555);
		$display("test writes done");
	endtask
	task automatic t_bad();
		logic [23:0] e;
		int b0;
		e = 24'(wr);
		b0 = bad_cnt;
		send(48'h0e_4321, 23);
		chk(24'(bad_cnt), 24'(b0 + 1));
		chk(24'(wr), e);
		send({22'h0, 24'h0e_4321, 2'b10}, 26);
		chk(24'(wr), fld(24'h0e_4321));
		$display("test bad frame done");
	endtask
	task automatic t_daisy();
		@(posedge clk) chain <= 1'b1;
		send(48'h0, 24);
		send({24'h8b_5a5a, 24'h03_c0de}, 48);
		chk(rx[23:0], 24'h8b_5a5a);
		chk(24'(wr), fld(24'h03_c0de));
		@(posedge clk) chain <= 1'b0;
		send(48'h0, 24);
		$display("test daisy done");
	endtask
	task automatic t_two_wire();
		int t0;
		@(posedge clk) mode <= 1'b0;
		st_hi <= 1'b1;
		repeat (10) @(posedge clk);
		t0 = tw_cnt;
		dac_host_model_inst.tw_start();
		dac_host_model_inst.tw_byte(8'hac, ack);
		chk(24'(ack), 24'h1);
		dac_host_model_inst.tw_byte(8'ha5, ack);
		chk(24'(ack), 24'h1);
		chk(24'(twb.data), 24'ha5);
		dac_host_model_inst.tw_start();
		dac_host_model_inst.tw_byte(8'ha8, ack);
		chk(24'(ack), 24'h0);
		dac_host_model_inst.tw_byte(8'h5a, ack);
		chk(24'(ack), 24'h0);
		dac_host_model_inst.tw_start();
		dac_host_model_inst.tw_byte(8'had, ack);
		chk(24'(ack), 24'h0);
		dac_host_model_inst.tw_stop();
		chk(24'(tw_cnt), 24'(t0 + 1));
		$display("test two-wire done");
	endtask
	// ==========================================================================
	// run control
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#1_000_000;
		err_count++;
		finish_test();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (6) @(posedge clk);
		t_readback();
		t_writes();
		t_bad();
		t_daisy();
		t_two_wire();
		finish_test();
	end
endmodule // dac_serial_host_interface_test
`default_nettype wire
